// >>> design/clk_ctrl_pkg.sv
// package of constants and types for the oscillator clock control block
// assumes a classic wishbone slave with 32-bit data and one word per register
// Behaviour
// - active_source_sel reports the running clock source, read only, eight codes.
// - requested_source_sel is writable, same encoding, names the next switch target.
// - both source fields load from configuration inputs at power-on reset.
// - with monitor config 01, source_switch_lock set blocks every clock switch.
// - pin_map_lock set makes pin-select writes ignored; clear lets them pass.
// - pll lock bit reads 1 when pll locked, else 0; a switch start forces 0 until lock drops before the new source is ready, or the switch ends.
// - clock_fail_flag sets on monitor failure; software reads and clears it.
// - secondary_osc_enable drives the secondary oscillator enable output.
// - software sets switch_request; hardware clears it when the switch completes.
// - control register writes need an unlock sequence before each write.
// - with recover_on_irq set, an interrupt clears reduction_enable.
// - reduction field divides instruction clock by 2^code, resets to 011.
// - reduction_enable at 1 applies the ratio, at 0 forces 1:1.
// - fast rc postscaler divides by 1,2,2,8,16,32,64,256; resets to 000.
// - pll output divider 00 /2, 01 /4 reset, 11 /8, 10 reserved.
// - pll input prescaler divides by field plus two; resets to zero.
// - pll multiplier is field plus two, resets to multiplier 50.
// - rc_trim is a six-bit two's complement trim, zero is nominal.
// - unimplemented bits read zero and ignore writes.
// - a switch toward the already active source aborts and clears the request.
// - valid switch clears lock and fail bits, waits ready then ten source edges.
// - on completion active field takes requested field, request bit clears.
package clk_ctrl_pkg;
    localparam logic [3:0] OFF_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFF_CLK_DIV = 4'h4;
    localparam logic [3:0] OFF_PLL_FBD = 4'h8;
    localparam logic [3:0] OFF_RC_TUNE = 4'hC;
    localparam logic [3:0] OFF_UNLOCK = 4'h1; // key port, an address no register uses
    localparam logic [15:0] UNLOCK_KEY1 = 16'h0057;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h00A8;
    // oscillator control field positions
    localparam int ACT_LSB = 12;
    localparam int REQ_LSB = 8;
    localparam int SWLOCK_BIT = 7;
    localparam int PINLOCK_BIT = 6;
    localparam int PLLLOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SECEN_BIT = 1;
    localparam int SWREQ_BIT = 0;
    localparam logic [15:0] OSC_CTRL_MASK = 16'h77EB;
    localparam logic [15:0] OSC_CTRL_WMASK = 16'h07C3;
    // clock divisor field positions
    localparam int ROI_BIT = 15;
    localparam int DOZE_LSB = 12;
    localparam int REDUCTION_ENABLE_BIT = 11;
    localparam int RCDIV_LSB = 8;
    localparam int POST_LSB = 6;
    localparam int PRE_LSB = 0;
    localparam logic [15:0] CLK_DIV_MASK = 16'hFFDF;
    localparam logic [15:0] CLK_DIV_RESET = 16'h3040;
    localparam logic [15:0] PLL_FBD_MASK = 16'h01FF;
    localparam logic [15:0] PLL_FBD_RESET = 16'h0030;
    localparam logic [15:0] RC_TUNE_MASK = 16'h003F;
    localparam logic [15:0] RC_TUNE_RESET = 16'h0000;
    localparam logic [1:0] MON_SWITCH_ONLY = 2'b01;
    localparam logic [1:0] POST_RESERVED = 2'b10;
    localparam logic [3:0] SETTLE_CYCLES = 4'd10;
    typedef enum logic [2:0] {
        SRC_FRC = 3'b000, SRC_FRC_PLL = 3'b001, SRC_PRI = 3'b010, SRC_PRI_PLL = 3'b011,
        SRC_SEC = 3'b100, SRC_LOW_POWER_INTERNAL_RC = 3'b101, SRC_FRC_16 = 3'b110, SRC_FRC_N = 3'b111
    } source_t;
    typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_READY = 2'b01, SW_SETTLE = 2'b11} switch_state_t;
    typedef struct packed {
        logic [7:0] cpuDivLog2;
        logic [8:0] rcDivide;
        logic [3:0] pllOutDiv;
        logic [5:0] pllInDiv;
        logic [9:0] pllMult;
        logic [5:0] rcTrim;
    } clock_setup_t;
endpackage

// >>> design/settle_counter.sv
// counts edges of the new source, after synchronising them to clk_sys
// assumes the source edge input is a slow toggling level
`timescale 1ns/1ns
module settle_counter (
    // system
    input wire logic clk_sys,
    input wire logic resetn,
    // control
    input wire logic start,
    input wire logic srcLevel,
    output logic done
);
    typedef struct packed {
        logic [2:0] sync;
        logic [3:0] count;
        logic run;
    } state_t;
    state_t stateReg;
    state_t stateNext;
    always_comb begin
        stateNext = stateReg;
        stateNext.sync = {stateReg.sync[1:0], srcLevel};
        if (start) begin
            stateNext.run = 1'b1;
            stateNext.count = 4'h0;
        end else if (stateReg.run && (stateReg.sync[2] ^ stateReg.sync[1])) begin
            // only sync[1] and sync[2] are compared; sync[0] feeds sync[1] only
            stateNext.count = stateReg.count + 4'h1;
            if (stateReg.count + 4'h1 == clk_ctrl_pkg::SETTLE_CYCLES)
                stateNext.run = 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!resetn)
            stateReg <= '0;
        else
            stateReg <= stateNext;
    end
    assign done = !stateReg.run && (stateReg.count == clk_ctrl_pkg::SETTLE_CYCLES) && !start;
endmodule

// >>> design/osc_clock_control.sv
// oscillator clock control registers and switch sequencer behind wishbone
// assumes analog oscillators, pll and fail-safe monitor outside; strobes synchronous
`timescale 1ns/1ns
module osc_clock_control (
    // system
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic porEvent,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration straps
    input wire logic [2:0] cfgInitSource,
    input wire logic [1:0] switchMonitorConfig,
    // oscillator and monitor status
    input wire logic pllLocked,
    input wire logic clockFailure,
    input wire logic sourceReady,
    input wire logic newSourceClk,
    input wire logic irqEvent,
    // pin-select write gate
    input wire logic pinSelWriteReq,
    output logic pinSelWriteAllow,
    // clock controls out
    output logic [2:0] activeSource,
    output logic [2:0] targetSource,
    output logic secondaryOscEnable,
    output logic reductionActive,
    output logic switchBusy,
    output clk_ctrl_pkg::clock_setup_t clockSetup
);
    typedef struct packed {
        logic [2:0] act;
        logic [2:0] req;
        logic swLock;
        logic pinLock;
        logic fail;
        logic secEn;
        logic swReq;
        logic [15:0] clock_divisor;
        logic [8:0] fbd;
        logic [5:0] trim;
        logic [1:0] unlockStep;
        clk_ctrl_pkg::switch_state_t sw;
        logic ack;
        logic [31:0] rdata;
        logic lockClear;
    } state_t;
    state_t stateReg;
    state_t stateNext;
    logic access;
    logic wrLow;
    logic [15:0] wdata;
    logic [15:0] oscView;
    logic settleStart;
    logic settleDone;
    logic pllLockRead;
    logic switchingEnabled;
    logic [2:0] doze;
    logic [2:0] rcDiv;
    logic [1:0] post;
    settle_counter settle (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(settleStart),
        .srcLevel(newSourceClk),
        .done(settleDone)
    );
    assign access = wb_cyc_i && wb_stb_i && !stateReg.ack;
    assign wrLow = access && wb_we_i && (wb_sel_i[1:0] == 2'b11);
    assign wdata = wb_dat_i[15:0];
    assign switchingEnabled = !switchMonitorConfig[1];
    assign pllLockRead = pllLocked && !stateReg.lockClear;
    assign oscView = {1'b0, stateReg.act, 1'b0, stateReg.req, stateReg.swLock, stateReg.pinLock,
        pllLockRead, 1'b0, stateReg.fail, 1'b0, stateReg.secEn, stateReg.swReq};
    assign settleStart = (stateReg.sw == clk_ctrl_pkg::SW_READY) && sourceReady;
    always_comb begin
        stateNext = stateReg;
        stateNext.ack = access;
        stateNext.rdata = 32'h0000_0000;
        if (access && !wb_we_i) begin
            unique case (wb_adr_i)
                clk_ctrl_pkg::OFF_OSC_CTRL: stateNext.rdata = {16'h0000, oscView};
                clk_ctrl_pkg::OFF_CLK_DIV: stateNext.rdata = {16'h0000, stateReg.clock_divisor & clk_ctrl_pkg::CLK_DIV_MASK};
                clk_ctrl_pkg::OFF_PLL_FBD: stateNext.rdata = {23'h00_0000, stateReg.fbd};
                clk_ctrl_pkg::OFF_RC_TUNE: stateNext.rdata = {26'h000_0000, stateReg.trim};
                default: stateNext.rdata = 32'h0000_0000;
            endcase
        end
        // unlock keys are written to the unimplemented index 1; any other write breaks the chain
        if (wrLow && wb_adr_i == clk_ctrl_pkg::OFF_UNLOCK) begin
            if (wdata == clk_ctrl_pkg::UNLOCK_KEY1)
                stateNext.unlockStep = 2'd1;
            else if (wdata == clk_ctrl_pkg::UNLOCK_KEY2 && stateReg.unlockStep == 2'd1)
                stateNext.unlockStep = 2'd2;
            else
                stateNext.unlockStep = 2'd0;
        end else if (access && wb_we_i) begin
            stateNext.unlockStep = 2'd0;
        end
        if (wrLow && wb_adr_i == clk_ctrl_pkg::OFF_OSC_CTRL && stateReg.unlockStep == 2'd2) begin
            if (stateReg.sw == clk_ctrl_pkg::SW_IDLE)
                stateNext.req = wdata[clk_ctrl_pkg::REQ_LSB +: 3];
            stateNext.swLock = wdata[clk_ctrl_pkg::SWLOCK_BIT] | stateReg.swLock;
            stateNext.pinLock = wdata[clk_ctrl_pkg::PINLOCK_BIT];
            stateNext.secEn = wdata[clk_ctrl_pkg::SECEN_BIT];
            if (!wdata[clk_ctrl_pkg::FAIL_BIT])
                stateNext.fail = 1'b0;
            if (wdata[clk_ctrl_pkg::SWREQ_BIT] && switchingEnabled)
                stateNext.swReq = 1'b1;
            if (!wdata[clk_ctrl_pkg::SWLOCK_BIT] && switchMonitorConfig == clk_ctrl_pkg::MON_SWITCH_ONLY)
                stateNext.swLock = 1'b0;
        end
        if (wrLow && wb_adr_i == clk_ctrl_pkg::OFF_CLK_DIV) begin
            stateNext.clock_divisor = wdata & clk_ctrl_pkg::CLK_DIV_MASK;
            if (wdata[clk_ctrl_pkg::POST_LSB +: 2] == clk_ctrl_pkg::POST_RESERVED)
                stateNext.clock_divisor[clk_ctrl_pkg::POST_LSB +: 2] = stateReg.clock_divisor[clk_ctrl_pkg::POST_LSB +: 2];
        end
        if (wrLow && wb_adr_i == clk_ctrl_pkg::OFF_PLL_FBD)
            stateNext.fbd = wdata[8:0];
        if (wrLow && wb_adr_i == clk_ctrl_pkg::OFF_RC_TUNE)
            stateNext.trim = wdata[5:0];
        if (irqEvent && stateReg.clock_divisor[clk_ctrl_pkg::ROI_BIT])
            stateNext.clock_divisor[clk_ctrl_pkg::REDUCTION_ENABLE_BIT] = 1'b0;
        unique case (stateReg.sw)
            clk_ctrl_pkg::SW_IDLE: begin
                if (stateReg.swReq) begin
                    if (stateReg.req == stateReg.act || (stateReg.swLock &&
                        switchMonitorConfig == clk_ctrl_pkg::MON_SWITCH_ONLY)) begin
                        stateNext.swReq = 1'b0;
                    end else begin
                        stateNext.fail = 1'b0;
                        stateNext.lockClear = 1'b1;
                        stateNext.sw = clk_ctrl_pkg::SW_READY;
                    end
                end
            end
            clk_ctrl_pkg::SW_READY: begin
                if (pllLocked == 1'b0)
                    stateNext.lockClear = 1'b0;
                if (sourceReady)
                    stateNext.sw = clk_ctrl_pkg::SW_SETTLE;
            end
            clk_ctrl_pkg::SW_SETTLE: begin
                if (settleDone) begin
                    stateNext.act = stateReg.req;
                    stateNext.swReq = 1'b0;
                    stateNext.lockClear = 1'b0;
                    stateNext.sw = clk_ctrl_pkg::SW_IDLE;
                end
            end
            default: stateNext.sw = clk_ctrl_pkg::SW_IDLE;
        endcase
        if (clockFailure)
            stateNext.fail = 1'b1;
        if (porEvent) begin
            stateNext.act = cfgInitSource;
            stateNext.req = cfgInitSource;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            stateReg <= '0;
            stateReg.clock_divisor <= clk_ctrl_pkg::CLK_DIV_RESET;
            stateReg.fbd <= clk_ctrl_pkg::PLL_FBD_RESET[8:0];
            stateReg.trim <= clk_ctrl_pkg::RC_TUNE_RESET[5:0];
            stateReg.sw <= clk_ctrl_pkg::SW_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end
    assign doze = stateReg.clock_divisor[clk_ctrl_pkg::DOZE_LSB +: 3];
    assign rcDiv = stateReg.clock_divisor[clk_ctrl_pkg::RCDIV_LSB +: 3];
    assign post = stateReg.clock_divisor[clk_ctrl_pkg::POST_LSB +: 2];
    always_comb begin
        clockSetup.cpuDivLog2 = stateReg.clock_divisor[clk_ctrl_pkg::REDUCTION_ENABLE_BIT] ? 8'(1 << doze) : 8'h01;
        unique case (rcDiv)
            3'd0: clockSetup.rcDivide = 9'd1;
            3'd1, 3'd2: clockSetup.rcDivide = 9'd2;
            3'd7: clockSetup.rcDivide = 9'd256;
            default: clockSetup.rcDivide = 9'(1 << rcDiv);
        endcase
        clockSetup.pllOutDiv = (post == 2'b11) ? 4'd8 : (post == 2'b01) ? 4'd4 : 4'd2;
        clockSetup.pllInDiv = 6'(stateReg.clock_divisor[clk_ctrl_pkg::PRE_LSB +: 5]) + 6'd2;
        clockSetup.pllMult = 10'(stateReg.fbd) + 10'd2;
        clockSetup.rcTrim = stateReg.trim;
    end
    assign wb_ack_o = stateReg.ack;
    assign wb_dat_o = stateReg.rdata;
    assign pinSelWriteAllow = pinSelWriteReq && !stateReg.pinLock;
    assign activeSource = stateReg.act;
    assign targetSource = stateReg.req;
    assign secondaryOscEnable = stateReg.secEn;
    assign reductionActive = stateReg.clock_divisor[clk_ctrl_pkg::REDUCTION_ENABLE_BIT];
    assign switchBusy = stateReg.sw != clk_ctrl_pkg::SW_IDLE;
endmodule

// >>> test/osc_clock_control_assertions.sv
// port-level assertions for the oscillator clock control block
// assumes one clk_sys domain with synchronous active-low reset
`timescale 1ns/1ns
module osc_clock_control_assertions (
    // system
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic porEvent,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // status and controls
    input wire logic pinSelWriteReq,
    input wire logic pinSelWriteAllow,
    input wire logic [2:0] activeSource,
    input wire logic switchBusy,
    input wire logic reductionActive,
    input wire clk_ctrl_pkg::clock_setup_t clockSetup
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_pin_gate: assert property (!pinSelWriteReq |-> !pinSelWriteAllow)
        else $error("pin-select write allowed without request");
    a_ratio_unity: assert property (!reductionActive |-> clockSetup.cpuDivLog2 == 8'h01)
        else $error("ratio not 1:1 with reduction off");
    a_ratio_power: assert property (reductionActive |-> $onehot(clockSetup.cpuDivLog2))
        else $error("reduction ratio not a power of two");
    a_prescale_range: assert property (clockSetup.pllInDiv inside {[2:33]})
        else $error("pll prescale out of range");
    a_mult_range: assert property (clockSetup.pllMult inside {[2:513]})
        else $error("pll multiplier out of range");
    a_postdiv_codes: assert property (clockSetup.pllOutDiv inside {2, 4, 8})
        else $error("pll output divider illegal");
    a_rc_div_codes: assert property (clockSetup.rcDivide inside {1, 2, 8, 16, 32, 64, 256})
        else $error("rc postscale illegal");
    a_source_hold: assert property ($changed(activeSource) |-> $past(switchBusy) || $past(porEvent))
        else $error("active source changed outside a switch");
    c_switch_done: cover property ($fell(switchBusy));
    c_irq_recover: cover property ($fell(reductionActive));
    c_pin_locked: cover property (pinSelWriteReq && !pinSelWriteAllow);
endmodule

bind osc_clock_control osc_clock_control_assertions chk (.clk_sys(clk_sys), .resetn(resetn),
    .porEvent(porEvent), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .pinSelWriteReq(pinSelWriteReq), .pinSelWriteAllow(pinSelWriteAllow), .activeSource(activeSource),
    .switchBusy(switchBusy), .reductionActive(reductionActive), .clockSetup(clockSetup));

// >>> test/testbench.sv
// self-checking bench for the oscillator clock control block
// assumes the wishbone timing and unlock keys of the package
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 0, resetn = 0, porEvent = 0, cyc = 0, stb = 0, we = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000, rdat, datO;
    logic [2:0] cfgSrc = 3'b010, actSrc, tgtSrc, c;
    logic [1:0] monCfg = 2'b01;
    logic pllLk = 0, fail = 0, srcRdy = 0, srcClk = 0, irq = 0, pinReq = 1;
    logic ack, pinAllow, secEn, redAct, busy;
    logic [15:0] d;
    logic [8:0] rcTab [8] = '{1, 2, 2, 8, 16, 32, 64, 256};
    clk_ctrl_pkg::clock_setup_t setup;
    int n_mismatch = 0, samples_checked = 0, i, k, n;

    osc_clock_control dut (.clk_sys(clk_sys), .resetn(resetn), .porEvent(porEvent), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(datO),
        .wb_ack_o(ack), .cfgInitSource(cfgSrc), .switchMonitorConfig(monCfg), .pllLocked(pllLk),
        .clockFailure(fail), .sourceReady(srcRdy), .newSourceClk(srcClk), .irqEvent(irq),
        .pinSelWriteReq(pinReq), .pinSelWriteAllow(pinAllow), .activeSource(actSrc), .targetSource(tgtSrc),
        .secondaryOscEnable(secEn), .reductionActive(redAct), .switchBusy(busy), .clockSetup(setup));

    initial forever #50 clk_sys = ~clk_sys;

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= wd;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 50);
        rdat = datO;
        cyc <= 0;
        stb <= 0;
        if (k >= 50) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] wd);
        bus(1, a, {16'h0000, wd});
    endtask
    task automatic expRd(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(0, a, 32'h0000_0000);
        check(nm, e, rdat);
    endtask
    task automatic unlockWr(input logic [15:0] wd);
        wr(clk_ctrl_pkg::OFF_UNLOCK, clk_ctrl_pkg::UNLOCK_KEY1);
        wr(clk_ctrl_pkg::OFF_UNLOCK, clk_ctrl_pkg::UNLOCK_KEY2);
        wr(4'h0, wd);
    endtask
    // w selects the strobe: 0 power-on, 1 interrupt, 2 clock failure
    task automatic pulse(input int w);
        @(posedge clk_sys);
        porEvent <= (w == 0);
        irq <= (w == 1);
        fail <= (w == 2);
        @(posedge clk_sys);
        porEvent <= 0;
        irq <= 0;
        fail <= 0;
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        void'($urandom(32'h5b71));
        repeat (16) @(posedge clk_sys);
        resetn <= 1;
        expRd("ctrl", 4'h0, 32'h0000_0000);
        expRd("div", 4'h4, 32'h0000_3040);
        expRd("fbd", 4'h8, 32'h0000_0030);
        expRd("tune", 4'hC, 32'h0000_0000);
        expRd("unmapped", 4'h6, 32'h0000_0000);
        pulse(0);
        expRd("por", 4'h0, 32'h0000_2200);
        for (i = 0; i < 8; i++) begin
            d = (i < 2) ? 16'hFFFF : 16'($urandom);
            wr(i[0] ? 4'h8 : 4'hC, d);
            expRd("rand", i[0] ? 4'h8 : 4'hC, {16'h0000, d & (i[0] ? 16'h01FF : 16'h003F)});
            if (i[0])
                check("mult", 32'(d[8:0]) + 2, 32'(setup.pllMult));
            else
                check("trim", 32'(d[5:0]), 32'(setup.rcTrim));
        end
        for (i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(4'h4, {1'b0, c, 1'b1, c, c[1:0], 3'b000, c});
            expRd("divcode", 4'h4, {17'h0, c, 1'b1, c, (c[1:0] == 2'b10) ? 2'b01 : c[1:0], 3'b000, c});
            check("rcdiv", 32'(rcTab[i]), 32'(setup.rcDivide));
            check("cpudiv", 32'h1 << i, 32'(setup.cpuDivLog2));
            check("post", (c[1:0] == 2'b11) ? 8 : ((c[1:0] == 2'b00) ? 2 : 4), 32'(setup.pllOutDiv));
            check("pre", i + 2, 32'(setup.pllInDiv));
        end
        pulse(1);
        check("noroi", 1, redAct);
        // nonzero reduction code, so only the cleared enable can give 1:1
        wr(4'h4, 16'hB800);
        pulse(1);
        check("roi", 0, redAct);
        check("unity", 1, 32'(setup.cpuDivLog2));
        expRd("roiread", 4'h4, 32'h0000_B000);
        pllLk <= 1;
        check("pinfree", 1, pinAllow);
        expRd("locked", 4'h0, 32'h0000_2220);
        wr(4'h0, 16'h0002);
        expRd("nokey", 4'h0, 32'h0000_2220);
        unlockWr(16'h0242);
        check("secen", 1, secEn);
        check("pinlock", 0, pinAllow);
        unlockWr(16'h0202);
        check("pinopen", 1, pinAllow);
        unlockWr(16'h0203);
        repeat (3) @(posedge clk_sys);
        expRd("redundant", 4'h0, 32'h0000_2222);
        pulse(2);
        expRd("fail", 4'h0, 32'h0000_222A);
        unlockWr(16'h0202);
        expRd("failclr", 4'h0, 32'h0000_2222);
        pulse(2);
        // fail bit written as 1 so only the switch itself can clear it
        unlockWr(16'h000B);
        repeat (4) @(posedge clk_sys);
        check("busy", 1, busy);
        expRd("switching", 4'h0, 32'h0000_2003);
        srcRdy <= 1;
        n = 0;
        for (i = 0; i < 400 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
            if (i % 3 == 0) begin
                srcClk <= ~srcClk;
                n++;
            end
        end
        check("idle", 0, busy);
        // a stuck switch would stall every later check
        if (busy !== 1'b0)
            end_of_test();
        check("settle", 1, n >= 10);
        check("newsrc", 0, actSrc);
        pllLk <= 0;
        expRd("done", 4'h0, 32'h0000_0002);
        monCfg <= 2'b11;
        unlockWr(16'h0103);
        expRd("swoff", 4'h0, 32'h0000_0102);
        check("noswitch", 0, busy);
        monCfg <= 2'b01;
        unlockWr(16'h0080);
        unlockWr(16'h0181);
        repeat (30) @(posedge clk_sys);
        check("lockhold", 0, actSrc);
        check("target", 1, tgtSrc);
        check("secoff", 0, secEn);
        pinReq <= 0;
        repeat (2) @(posedge clk_sys);
        end_of_test();
    end
endmodule
